// ### fssl_host.sv
// Host controller that drives the flash command interface.
// Assumes an APB master and an asynchronous parallel flash on the pins.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fssl_host (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins
    output fssl_pkg::fssl_bus_t flashBus,
    input wire logic [15:0] flashDataIn,
    input wire logic flashStatusPin
);
    import fssl_pkg::*;

    fssl_state_t state_reg, state_next;
    fssl_bus_t bus_reg, bus_next;
    logic [3:0] op_reg, op_next;
    logic [7:0] arg_reg, arg_next;
    logic [23:0] addr_reg, addr_next;
    logic [1:0] step_reg, step_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [15:0] result_reg, result_next;
    logic busy_reg, busy_next;
    logic refused_reg, refused_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [15:0] dataSync;
    logic stsSync;
    logic [7:0] cmdByte;
    logic apbWrite;
    logic sr7;
    logic cfgBlocked;

    fssl_sync #(.W(17)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din({flashStatusPin, flashDataIn}),
        .dout({stsSync, dataSync})
    );

    assign apbWrite = psel && penable && pwrite;
    assign sr7 = result_reg[SR_READY];
    // Ready alone is not enough: a suspended device also shows bit 7 set
    assign cfgBlocked = !sr7 || result_reg[SR_ERASE_SUSP] || result_reg[SR_PROG_SUSP];

    // Sequence table: command byte for each write step
    always_comb begin
        cmdByte = CMD_READ_STATUS;
        case (op_reg)
            OP_SUSPEND: cmdByte = CMD_SUSPEND;
            OP_RESUME: cmdByte = CMD_RESUME;
            OP_STS_CFG: cmdByte = (step_reg == 2'd0) ? CMD_STS_SETUP : arg_reg;
            OP_LOCK: cmdByte = (step_reg == 2'd0) ? CMD_LOCK_SETUP : CMD_LOCK_CONFIRM;
            OP_UNLOCK_ALL: cmdByte = (step_reg == 2'd0) ? CMD_LOCK_SETUP : CMD_UNLOCK_CONFIRM;
            OP_CLEAR_STATUS: cmdByte = CMD_CLEAR_STATUS;
            OP_READ_LOCK: cmdByte = CMD_READ_INFO;
            OP_READ_ARRAY: cmdByte = CMD_READ_ARRAY;
            default: cmdByte = CMD_READ_STATUS;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        bus_next = bus_reg;
        op_next = op_reg;
        arg_next = arg_reg;
        addr_next = addr_reg;
        step_next = step_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        busy_next = busy_reg;
        refused_next = refused_reg;
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_ADDR: prdata_next = {8'h00, addr_reg};
                REG_STATUS: prdata_next = {28'h0000000, stsSync, sr7, refused_reg, busy_reg};
                REG_RESULT: prdata_next = {16'h0000, result_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
        if (apbWrite && paddr == REG_ADDR && !busy_reg) begin
            addr_next = pwdata[23:0];
        end
        case (state_reg)
            S_IDLE: begin
                if (apbWrite && paddr == REG_CMD && !busy_reg) begin
                    op_next = pwdata[3:0];
                    arg_next = pwdata[15:8];
                    step_next = 2'd0;
                    refused_next = 1'b0;
                    // Config only when last status showed ready and not suspended, no code 10
                    if (pwdata[3:0] == OP_STS_CFG && (cfgBlocked || pwdata[9:8] == STS_UNSUPPORTED
                            || pwdata[15:10] != 6'h00)) begin
                        refused_next = 1'b1;
                    end else if (pwdata[3:0] == OP_READ_STATUS) begin
                        busy_next = 1'b1;
                        state_next = S_POLL;
                    end else begin
                        busy_next = 1'b1;
                        state_next = S_WR;
                    end
                end
            end
            S_WR: begin
                bus_next.addr = (op_reg == OP_LOCK) ? addr_reg : 24'h000000;
                bus_next.dataOut = {8'h00, cmdByte};
                bus_next.dataOe = 1'b1;
                bus_next.chipEn_n = 1'b0;
                bus_next.writeEn_n = 1'b0;
                cnt_next = cnt_reg + 4'd1;
                if (cnt_reg == STROBE_CNT) begin
                    bus_next.writeEn_n = 1'b1;
                    bus_next.chipEn_n = 1'b1;
                    cnt_next = 4'd0;
                    state_next = S_GAP;
                end
            end
            S_GAP: begin
                bus_next.dataOe = 1'b0;
                cnt_next = cnt_reg + 4'd1;
                if (cnt_reg == STROBE_CNT) begin
                    cnt_next = 4'd0;
                    if ((op_reg == OP_STS_CFG || op_reg == OP_LOCK || op_reg == OP_UNLOCK_ALL)
                            && step_reg == 2'd0) begin
                        step_next = 2'd1;
                        state_next = S_WR;
                    end else if (op_reg == OP_READ_LOCK) begin
                        bus_next.addr = addr_reg | LOCK_INFO_OFFSET;
                        state_next = S_RD;
                    end else if (op_reg == OP_READ_ARRAY || op_reg == OP_CLEAR_STATUS) begin
                        // No array read cycle is ever run here
                        state_next = S_DONE;
                    end else begin
                        // Suspend keeps status mode, so status can be polled directly
                        state_next = S_POLL;
                    end
                end
            end
            S_POLL, S_RD: begin
                bus_next.chipEn_n = 1'b0;
                bus_next.outEn_n = 1'b0;
                cnt_next = cnt_reg + 4'd1;
                // Extra cycles cover the two-flop data synchroniser
                if (cnt_reg == STROBE_CNT + 4'd2) begin
                    result_next = (state_reg == S_RD) ? {15'h0000, dataSync[0]} : dataSync;
                    bus_next.chipEn_n = 1'b1;
                    bus_next.outEn_n = 1'b1;
                    cnt_next = 4'd0;
                    state_next = (state_reg == S_RD) ? S_DONE : S_CHECK;
                end
            end
            S_CHECK: begin
                // Poll until ready; suspend counts as done on bit 7 alone, suspend bits are not checked
                if (dataSync[SR_READY] || result_reg[SR_READY]) begin
                    state_next = S_DONE;
                end else begin
                    state_next = S_POLL;
                end
            end
            S_DONE: begin
                busy_next = 1'b0;
                state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
            bus_reg <= '{addr: 24'h000000, dataOut: 16'h0000, dataOe: 1'b0,
                         chipEn_n: 1'b1, writeEn_n: 1'b1, outEn_n: 1'b1, reset_n: 1'b1};
            op_reg <= 4'h0;
            arg_reg <= 8'h00;
            addr_reg <= 24'h000000;
            step_reg <= 2'd0;
            cnt_reg <= 4'd0;
            result_reg <= 16'h0000;
            busy_reg <= 1'b0;
            refused_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            bus_reg <= bus_next;
            op_reg <= op_next;
            arg_reg <= arg_next;
            addr_reg <= addr_next;
            step_reg <= step_next;
            cnt_reg <= cnt_next;
            result_reg <= result_next;
            busy_reg <= busy_next;
            refused_reg <= refused_next;
            prdata_reg <= prdata_next;
        end
    end

    assign flashBus = bus_reg;
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Status pin config write is refused while last status showed busy
    property p_cfg_gate;
        @(posedge clk) disable iff (!arst_n)
        (state_reg == S_IDLE && apbWrite && paddr == REG_CMD && !busy_reg
         && pwdata[3:0] == OP_STS_CFG && !sr7) |=> (refused_reg && state_reg == S_IDLE);
    endproperty
    a_cfg_gate: assert property (p_cfg_gate) else $error("config issued while busy");

    property p_no_code10;
        @(posedge clk) disable iff (!arst_n)
        (state_reg == S_WR && op_reg == OP_STS_CFG && step_reg == 2'd1)
            |-> (arg_reg[1:0] != STS_UNSUPPORTED);
    endproperty
    a_no_code10: assert property (p_no_code10) else $error("unsupported config sent");

    property p_cfg_second;
        @(posedge clk) disable iff (!arst_n)
        (state_reg == S_GAP && op_reg == OP_STS_CFG && step_reg == 2'd0 && cnt_reg == STROBE_CNT)
            |=> (state_reg == S_WR && step_reg == 2'd1);
    endproperty
    a_cfg_second: assert property (p_cfg_second) else $error("config code not next");
    property p_susp_code;
        @(posedge clk) disable iff (!arst_n)
        (!bus_reg.writeEn_n && op_reg == OP_SUSPEND) |-> (bus_reg.dataOut[7:0] == CMD_SUSPEND);
    endproperty
    a_susp_code: assert property (p_susp_code) else $error("wrong suspend code");
    property p_resume_code;
        @(posedge clk) disable iff (!arst_n)
        (!bus_reg.writeEn_n && op_reg == OP_RESUME) |-> (bus_reg.dataOut[7:0] == CMD_RESUME);
    endproperty
    a_resume_code: assert property (p_resume_code) else $error("wrong resume code");
    property p_lock_addr;
        @(posedge clk) disable iff (!arst_n)
        (!bus_reg.writeEn_n && op_reg == OP_LOCK) |-> (bus_reg.addr == addr_reg);
    endproperty
    a_lock_addr: assert property (p_lock_addr) else $error("lock sent off block");
    property p_susp_done;
        @(posedge clk) disable iff (!arst_n)
        (state_reg == S_DONE && op_reg == OP_SUSPEND) |-> result_reg[SR_READY];
    endproperty
    a_susp_done: assert property (p_susp_done) else $error("suspend ended unready");
endmodule
`default_nettype wire

// ### fssl_pkg.sv
// Package for the flash suspend/status-pin/lock host controller.
// Assumes a 100 MHz clock and an APB slave for the controller's own registers.
package fssl_pkg;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'hd0;
    localparam logic [7:0] CMD_STS_SETUP = 8'hb8;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
    localparam logic [7:0] CMD_UNLOCK_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_INFO = 8'h90;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [23:0] LOCK_INFO_OFFSET = 24'h000002;
    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_UNLOCK_ERR = 5;
    localparam int SR_LOCK_ERR = 4;
    localparam int SR_PROG_SUSP = 2;
    localparam logic [1:0] STS_LEVEL = 2'b00;
    localparam logic [1:0] STS_ERASE_PULSE = 2'b01;
    localparam logic [1:0] STS_UNSUPPORTED = 2'b10;
    localparam logic [1:0] STS_BOTH_PULSE = 2'b11;
    // Register byte addresses of the controller's own APB map
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0c;
    // Operation codes written to REG_CMD bits [3:0]
    localparam logic [3:0] OP_SUSPEND = 4'h1;
    localparam logic [3:0] OP_RESUME = 4'h2;
    localparam logic [3:0] OP_STS_CFG = 4'h3;
    localparam logic [3:0] OP_LOCK = 4'h4;
    localparam logic [3:0] OP_UNLOCK_ALL = 4'h5;
    localparam logic [3:0] OP_CLEAR_STATUS = 4'h6;
    localparam logic [3:0] OP_READ_LOCK = 4'h7;
    localparam logic [3:0] OP_READ_STATUS = 4'h8;
    localparam logic [3:0] OP_READ_ARRAY = 4'h9;
    // Bus cycle timing in ns and cycles at 100 MHz
    localparam int CLK_NS = 10;
    localparam int STROBE_NS = 60;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dataOut;
        logic dataOe;
        logic chipEn_n;
        logic writeEn_n;
        logic outEn_n;
        logic reset_n;
    } fssl_bus_t;
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_WR = 7'b0000010,
        S_GAP = 7'b0000100,
        S_RD = 7'b0001000,
        S_POLL = 7'b0010000,
        S_CHECK = 7'b0100000,
        S_DONE = 7'b1000000
    } fssl_state_t;
endpackage

// ### fssl_sync.sv
// Two-flop synchroniser for pins from the flash.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module fssl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= din;
            stage2_reg <= stage1_reg;
        end
    end
    assign dout = stage2_reg;
endmodule
`default_nettype wire

// ### fssl_flash_model.sv
// Behavioural model of the parallel flash that sits on the controller's pins.
// Assumes the bench starts program or erase work through start_op.
`timescale 1ns/1ps
`default_nettype none
module fssl_flash_model #(
    parameter int OP_TICKS = 200,
    parameter int SUSP_TICKS = 20,
    parameter int PULSE_TICKS = 50
) (
    // Flash pins
    input wire fssl_pkg::fssl_bus_t flashBus,
    output logic [15:0] flashDataIn,
    output logic flashStatusPin,
    // Supply condition
    input wire logic supplyLow
);
    import fssl_pkg::*;
    logic [7:0] statReg = 8'h80;
    logic [1:0] pinCfg = 2'b00;
    logic [7:0] pending = 8'h00;
    logic [7:0] lastCmd = 8'h00;
    logic [127:0] lockBits = '0;
    logic [1:0] readMode = 2'd0;
    logic [15:0] lastOut = 16'h0000;
    logic [15:0] rdVal;
    logic progRun = 1'b0;
    logic eraseRun = 1'b0;
    int progLeft = 0;
    int eraseLeft = 0;
    int suspLeft = 0;
    int pulseLeft = 0;

    task automatic start_op(input bit prog);
        if (prog) begin
            progRun = 1'b1;
            progLeft = OP_TICKS;
        end else begin
            eraseRun = 1'b1;
            eraseLeft = OP_TICKS;
        end
        statReg[7] = 1'b0;
    endtask

    task automatic finish_op(input bit prog);
        if (prog) progRun = 1'b0;
        else eraseRun = 1'b0;
        statReg[7] = 1'b1;
        if (pinCfg[prog ? 1 : 0]) pulseLeft = PULSE_TICKS;
    endtask

    // Device has no clock; a 10 ns tick paces internal work
    always #10 begin
        if (pulseLeft > 0) pulseLeft--;
        if (suspLeft > 0) begin
            suspLeft--;
            if (suspLeft == 0) begin
                if (progRun && !statReg[2]) statReg[2] = 1'b1;
                else statReg[6] = 1'b1;
                statReg[7] = 1'b1;
            end
        end else if (progRun && !statReg[2]) begin
            if (--progLeft == 0) finish_op(1'b1);
        end else if (eraseRun && !statReg[6]) begin
            if (--eraseLeft == 0) finish_op(1'b0);
        end
    end

    // Reset pin aborts all work and restores level mode
    always @(negedge flashBus.reset_n) begin
        progRun = 1'b0;
        eraseRun = 1'b0;
        suspLeft = 0;
        pinCfg = STS_LEVEL;
        statReg = 8'h80;
    end

    // Both strobes rise together; latch on the earlier of the two
    always @(posedge (flashBus.writeEn_n | flashBus.chipEn_n)) begin
        if (flashBus.dataOe) begin
            lastCmd = flashBus.dataOut[7:0];
            if (pending == CMD_STS_SETUP) begin
                if (flashBus.dataOut[7:2] != 6'h00 || lastCmd[1:0] == STS_UNSUPPORTED) begin
                    statReg[5:4] = 2'b11;
                end else begin
                    pinCfg = lastCmd[1:0];
                end
                pending = 8'h00;
            end else if (pending == CMD_LOCK_SETUP) begin
                if (!statReg[7] || statReg[6] || statReg[2] || supplyLow) begin
                    if (lastCmd == CMD_LOCK_CONFIRM) statReg[4] = 1'b1;
                    else statReg[5] = 1'b1;
                end else if (lastCmd == CMD_LOCK_CONFIRM) begin
                    lockBits[flashBus.addr[23:17]] = 1'b1;
                end else begin
                    lockBits = '0;
                end
                statReg[7] = 1'b1;
                pending = 8'h00;
            end else begin
                case (lastCmd)
                    CMD_SUSPEND: if (!statReg[7]) suspLeft = SUSP_TICKS;
                    CMD_RESUME: begin
                        readMode = 2'd0;
                        if (statReg[2]) statReg[2] = 1'b0;
                        else if (statReg[6]) statReg[6] = 1'b0;
                        if (progRun || eraseRun) statReg[7] = 1'b0;
                    end
                    CMD_STS_SETUP, CMD_LOCK_SETUP: begin
                        pending = lastCmd;
                        readMode = 2'd0;
                    end
                    CMD_READ_STATUS: readMode = 2'd0;
                    CMD_READ_INFO: readMode = 2'd1;
                    CMD_READ_ARRAY: readMode = 2'd2;
                    CMD_CLEAR_STATUS: statReg[5:1] = 5'h00;
                    default: ;
                endcase
            end
        end
    end

    // Lock state only at block base plus the lock offset
    assign rdVal = (readMode == 2'd0) ? {8'h00, statReg} :
        (readMode == 2'd1) ? {15'h0000, lockBits[flashBus.addr[23:17]] &
        (flashBus.addr[16:0] == LOCK_INFO_OFFSET[16:0])} : 16'hffff;
    always @(posedge flashBus.outEn_n) lastOut = rdVal;
    // Released bus shows the inverse so a stale sample cannot pass
    assign flashDataIn = (!flashBus.chipEn_n && !flashBus.outEn_n) ? rdVal : ~lastOut;
    assign flashStatusPin = (pinCfg == STS_LEVEL) ? statReg[7] : (pulseLeft == 0);
endmodule
`default_nettype wire

// ### test_flash_suspend_status_lock_control.sv
// Self-checking bench for the flash host controller.
// Assumes the flash model file is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_flash_suspend_status_lock_control;
    import fssl_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, supplyLow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, res;
    logic pready, pslverr, flashStatusPin;
    logic [15:0] flashDataIn;
    fssl_bus_t flashBus;
    int errTotal = 0, checkCount = 0;

    always #5 clk = ~clk;
    fssl_host uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashBus(flashBus), .flashDataIn(flashDataIn),
        .flashStatusPin(flashStatusPin));
    fssl_flash_model model (.flashBus(flashBus), .flashDataIn(flashDataIn),
        .flashStatusPin(flashStatusPin), .supplyLow(supplyLow));

    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Wait on pready alone; only the watchdog ends a stuck transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Start an operation, then poll until busy drops; only the watchdog bounds the wait
    task automatic run_op(input logic [3:0] op, input logic [7:0] code);
        logic [31:0] st;
        apb(1'b1, REG_CMD, {16'h0000, code, 4'h0, op}, st);
        repeat (2) @(posedge clk);
        do begin
            apb(1'b0, REG_STATUS, 32'h0, st);
        end while (st[0] !== 1'b0);
        apb(1'b0, REG_RESULT, 32'h0, res);
    endtask

    task automatic t_reset;
        logic [31:0] st;
        apb(1'b0, REG_STATUS, 32'h0, st);
        check(st[0], 1'b0);
        check({pready, pslverr}, 2'b10);
        apb(1'b0, REG_RESULT, 32'h0, st);
        check(st, 32'h0);
        apb(1'b1, 8'h10, {28'h0, OP_SUSPEND}, st);
        repeat (3) @(posedge clk);
        apb(1'b0, REG_STATUS, 32'h0, st);
        check(st[0], 1'b0);
        check(model.lastCmd, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_pin_cfg;
        logic [7:0] codes[5] = '{8'h02, 8'h04, 8'h03, 8'h01, 8'h00};
        logic [1:0] cfgs[5] = '{2'b00, 2'b00, 2'b11, 2'b01, 2'b00};
        logic [31:0] st;
        run_op(OP_STS_CFG, 8'h03);
        apb(1'b0, REG_STATUS, 32'h0, st);
        check(st[1], 1'b1);
        check(model.pinCfg, STS_LEVEL);
        run_op(OP_READ_STATUS, 8'h00);
        check(res, 32'h80);
        for (int i = 0; i < 5; i++) begin
            run_op(OP_STS_CFG, codes[i]);
            apb(1'b0, REG_STATUS, 32'h0, st);
            check(st[1], i < 2);
            check(model.pinCfg, cfgs[i]);
        end
        $display("pin config test done");
    endtask

    task automatic t_suspend;
        logic [31:0] st;
        apb(1'b1, REG_ADDR, 32'h020000, st);
        model.start_op(1'b0);
        run_op(OP_SUSPEND, 8'h00);
        check(res, 32'hc0);
        check(model.lastCmd, CMD_SUSPEND);
        apb(1'b0, REG_STATUS, 32'h0, st);
        check(st[3], 1'b1);
        run_op(OP_STS_CFG, 8'h01);
        apb(1'b0, REG_STATUS, 32'h0, st);
        check(st[1], 1'b1);
        check(model.pinCfg, STS_LEVEL);
        run_op(OP_LOCK, 8'h00);
        check(res, 32'hd0);
        check(model.lockBits[1], 1'b0);
        run_op(OP_CLEAR_STATUS, 8'h00);
        run_op(OP_READ_STATUS, 8'h00);
        check(res, 32'hc0);
        model.start_op(1'b1);
        run_op(OP_SUSPEND, 8'h00);
        check(res, 32'hc4);
        run_op(OP_RESUME, 8'h00);
        check(res, 32'hc0);
        run_op(OP_RESUME, 8'h00);
        check(res, 32'h80);
        $display("suspend test done");
    endtask

    task automatic t_lock;
        logic [31:0] st;
        apb(1'b1, REG_ADDR, 32'h060000, st);
        run_op(OP_LOCK, 8'h00);
        check(res, 32'h80);
        run_op(OP_READ_LOCK, 8'h00);
        check(res[0], 1'b1);
        run_op(OP_UNLOCK_ALL, 8'h00);
        check(res, 32'h80);
        run_op(OP_READ_LOCK, 8'h00);
        check(res[0], 1'b0);
        supplyLow = 1'b1;
        run_op(OP_LOCK, 8'h00);
        check(res, 32'h90);
        supplyLow = 1'b0;
        run_op(OP_CLEAR_STATUS, 8'h00);
        run_op(OP_READ_STATUS, 8'h00);
        check(res, 32'h80);
        run_op(OP_READ_ARRAY, 8'h00);
        check(model.readMode, 2'd2);
        check(model.lastCmd, CMD_READ_ARRAY);
        $display("lock test done");
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #500_000;
        errTotal++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_pin_cfg();
        t_suspend();
        t_lock();
        report_and_stop();
    end
endmodule
`default_nettype wire
